/* rtl/sslp_pkg.sv */
// Purpose: constants and types for the swing and lane power control
// Assumes: 4 ports, 8 lanes in 2 quads, 100 MHz core_clk
// Notes:   register offsets are byte addresses on a 32-bit word bus
// Behaviour
// - ports run full swing; low_swing_enable selects half-level low swing.
// - low swing turns de-emphasis off, ignoring selectable/compliance settings.
// - current de-emphasis status is invalid while low swing is on.
// - gen1 low-swing drive code 0x00..0x0f from low_swing_gen1_level.
// - gen2 low-swing drive code 0x00..0x0f from low_swing_gen2_level.
// - compliance with low swing uses transmit_margin low entry, no de-emphasis.
// - new transmit_margin applies only in a margin-changing LTSSM state.
// - each lane has independent rx_eq_zero and rx_eq_boost controls.
// - disabled x4 or x8 port puts its one or two quads in deep power.
// - quad whose lanes all belong to disabled ports goes deep.
// - enabled port: quads on, used lanes active, unused lanes down.
// - lane is used if a partner was detected on it in Detect.
// - used lanes are re-evaluated on every return to Detect.
// - width-reduced inactive lanes sit in P1, idle tx, rx termination on.
// - quad_power_down powers the quad down for every sharing port.
package sslp_pkg;
    localparam int NPORT = 4;
    localparam int NLANE = 8;
    localparam int NQUAD = 2;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] ADDR_SWING  = 8'h00;
    localparam logic [7:0] ADDR_LEVEL  = 8'h04;
    localparam logic [7:0] ADDR_MARGIN = 8'h08;
    localparam logic [7:0] ADDR_PORT   = 8'h0c;
    localparam logic [7:0] ADDR_EQZ    = 8'h10;
    localparam logic [7:0] ADDR_EQB    = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_LPWR   = 8'h1c;
    localparam int SW_LOWSW     = 0;
    localparam int SW_SELDEEMPH = 4;
    localparam int SW_CMPDEEMPH = 8;
    localparam int SW_QPD       = 12;
    localparam int PC_EN    = 0;
    localparam int PC_OWNER = 8;
    localparam int ST_USED  = 0;
    localparam int ST_QDEEP = 8;
    localparam int ST_APPTM = 12;
    localparam logic [31:0] RST_PORT   = 32'h00aa_500f;
    localparam logic [31:0] RST_LEVEL  = 32'h5555_5555;
    localparam logic [31:0] RST_EQ     = 32'h0000_0000;
    localparam logic [2:0]  MARGIN_NORMAL = 3'h0;
    // ************************************************************
    // link state codes, one-hot
    // ************************************************************
    localparam logic [4:0] LT_DETECT = 5'h01;
    localparam logic [4:0] LT_COMPL  = 5'h02;
    localparam logic [4:0] LT_RLOCK  = 5'h04;
    localparam logic [4:0] LT_L0     = 5'h08;
    localparam logic [4:0] LT_OTHER  = 5'h10;
    // lane power codes
    localparam logic [1:0] LP_P0   = 2'h0;
    localparam logic [1:0] LP_P1   = 2'h1;
    localparam logic [1:0] LP_P2   = 2'h2;
    localparam logic [1:0] LP_DEEP = 2'h3;
    typedef struct packed {
        logic       lowSwing;
        logic       deemphOn;
        logic       marginActive;
        logic [2:0] marginSel;
        logic [3:0] level;
    } sslp_tx_s;
    typedef struct packed {
        logic valid;
        logic deemph;
    } sslp_lsts_s;
endpackage

/* rtl/sslp_ctrl.sv */
// Purpose: transmit swing mode and lane/quad power decisions
// Assumes: link inputs synchronous to core_clk
// Notes:   analog codes only; drive levels themselves live in the PHY
module sslp_ctrl (
    // clock and reset
    input  wire logic                          core_clk,
    input  wire logic                          rstn,
    // register port
    input  wire logic [7:0]                    regAddr,
    input  wire logic [31:0]                   regWrData,
    input  wire logic                          regWrEn,
    input  wire logic                          regRdEn,
    output logic [31:0]                        regRdData,
    // link state per port
    input  wire logic [sslp_pkg::NPORT-1:0][4:0] ltssmState,
    input  wire logic [sslp_pkg::NPORT-1:0]    gen2Rate,
    // lane status from the phy
    input  wire logic [sslp_pkg::NLANE-1:0]    partnerDetect,
    input  wire logic [sslp_pkg::NLANE-1:0]    laneActive,
    // transmitter and status controls per port
    output sslp_pkg::sslp_tx_s [sslp_pkg::NPORT-1:0]   txCtrl,
    output sslp_pkg::sslp_lsts_s [sslp_pkg::NPORT-1:0] linkStatusTwo,
    // receiver equalizer per lane
    output logic [sslp_pkg::NLANE-1:0][3:0]    rxEqZero,
    output logic [sslp_pkg::NLANE-1:0][3:0]    rxEqBoost,
    // power states
    output logic [sslp_pkg::NLANE-1:0][1:0]    lanePower,
    output logic [sslp_pkg::NQUAD-1:0]         quadOn
);
    import sslp_pkg::*;

    // ************************************************************
    // registers
    // ************************************************************
    logic [15:0]            swingCtrl;
    logic [31:0]            levelCtrl;
    logic [11:0]            marginCtrl;
    logic [31:0]            portCtrl;
    logic [NPORT-1:0][2:0]  marginApplied;
    logic [NLANE-1:0]       laneUsed;
    logic [NQUAD-1:0]       quadDeep;
    logic [NPORT-1:0]       inCompl;

    function automatic logic [1:0] ownerOf(input logic [31:0] pc,
                                           input int lane);
        ownerOf = pc[PC_OWNER + 2*lane +: 2];
    endfunction

    function automatic logic portEnabled(input logic [31:0] pc,
                                         input int lane);
        portEnabled = pc[PC_EN + int'(ownerOf(pc, lane))];
    endfunction

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            swingCtrl  <= 16'h0000;
            levelCtrl  <= RST_LEVEL;
            marginCtrl <= 12'h000;
            portCtrl   <= RST_PORT;
        end else if (regWrEn) begin
            if (regAddr == ADDR_SWING) begin
                swingCtrl <= regWrData[15:0];
            end else if (regAddr == ADDR_LEVEL) begin
                levelCtrl <= regWrData;
            end else if (regAddr == ADDR_MARGIN) begin
                marginCtrl <= regWrData[11:0];
            end else if (regAddr == ADDR_PORT) begin
                portCtrl <= regWrData;
            end
        end
    end

    // equalizer fields go straight to the lanes, no coupling between them
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rxEqZero  <= RST_EQ;
            rxEqBoost <= RST_EQ;
        end else if (regWrEn) begin
            if (regAddr == ADDR_EQZ) begin
                rxEqZero <= regWrData;
            end else if (regAddr == ADDR_EQB) begin
                rxEqBoost <= regWrData;
            end
        end
    end

    // ************************************************************
    // read port, data only in the cycle after the strobe
    // ************************************************************
    logic [31:0] next_rdData;

    always_comb begin
        next_rdData = 32'h0000_0000;
        if (regAddr == ADDR_SWING) begin
            next_rdData[15:0] = swingCtrl;
        end else if (regAddr == ADDR_LEVEL) begin
            next_rdData = levelCtrl;
        end else if (regAddr == ADDR_MARGIN) begin
            next_rdData[11:0] = marginCtrl;
        end else if (regAddr == ADDR_PORT) begin
            next_rdData = portCtrl;
        end else if (regAddr == ADDR_EQZ) begin
            next_rdData = rxEqZero;
        end else if (regAddr == ADDR_EQB) begin
            next_rdData = rxEqBoost;
        end else if (regAddr == ADDR_STATUS) begin
            next_rdData[ST_USED +: NLANE]    = laneUsed;
            next_rdData[ST_QDEEP +: NQUAD]   = quadDeep;
            next_rdData[ST_APPTM +: 3*NPORT] = marginApplied;
        end else if (regAddr == ADDR_LPWR) begin
            next_rdData[2*NLANE-1:0] = lanePower;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            regRdData <= 32'h0000_0000;
        end else if (regRdEn) begin
            regRdData <= next_rdData;
        end else begin
            regRdData <= 32'h0000_0000;
        end
    end

    // ************************************************************
    // margin capture and swing per port
    // ************************************************************
    // margin changes mid-link would glitch the line; hold until allowed
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            marginApplied <= '0;
        end else begin
            for (int p = 0; p < NPORT; p++) begin
                if (ltssmState[p] == LT_RLOCK ||
                    ltssmState[p] == LT_COMPL) begin
                    marginApplied[p] <= marginCtrl[3*p +: 3];
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            inCompl <= '0;
        end else begin
            for (int p = 0; p < NPORT; p++) begin
                inCompl[p] <= (ltssmState[p] == LT_COMPL);
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            txCtrl        <= '0;
            linkStatusTwo <= '0;
        end else begin
            for (int p = 0; p < NPORT; p++) begin
                txCtrl[p].lowSwing <= swingCtrl[SW_LOWSW + p];
                if (swingCtrl[SW_LOWSW + p]) begin
                    txCtrl[p].deemphOn <= 1'b0;
                end else if (inCompl[p]) begin
                    txCtrl[p].deemphOn <= swingCtrl[SW_CMPDEEMPH + p];
                end else begin
                    txCtrl[p].deemphOn <= swingCtrl[SW_SELDEEMPH + p];
                end
                txCtrl[p].marginActive <= inCompl[p] ||
                    (marginApplied[p] != MARGIN_NORMAL);
                txCtrl[p].marginSel <= marginApplied[p];
                if (!swingCtrl[SW_LOWSW + p]) begin
                    txCtrl[p].level <= 4'h0;
                end else if (gen2Rate[p]) begin
                    txCtrl[p].level <= levelCtrl[8*p+4 +: 4];
                end else begin
                    txCtrl[p].level <= levelCtrl[8*p +: 4];
                end
                linkStatusTwo[p].valid <= !swingCtrl[SW_LOWSW + p];
                linkStatusTwo[p].deemph <= swingCtrl[SW_LOWSW + p] ? 1'b0 :
                    (inCompl[p] ? swingCtrl[SW_CMPDEEMPH + p]
                                : swingCtrl[SW_SELDEEMPH + p]);
            end
        end
    end

    // ************************************************************
    // lane usage, refreshed on every pass through Detect
    // ************************************************************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            laneUsed <= '0;
        end else begin
            for (int l = 0; l < NLANE; l++) begin
                if (ltssmState[ownerOf(portCtrl, l)] == LT_DETECT) begin
                    laneUsed[l] <= partnerDetect[l];
                end
            end
        end
    end

    // ************************************************************
    // quad and lane power
    // ************************************************************
    logic [NQUAD-1:0] next_quadDeep;

    // a disabled x4 or x8 port owns whole quads, so the all-disabled
    // test covers it as well as mixed x1/x2 quads
    always_comb begin
        for (int q = 0; q < NQUAD; q++) begin
            next_quadDeep[q] = swingCtrl[SW_QPD + q];
            if (!portEnabled(portCtrl, 4*q) &&
                !portEnabled(portCtrl, 4*q+1) &&
                !portEnabled(portCtrl, 4*q+2) &&
                !portEnabled(portCtrl, 4*q+3)) begin
                next_quadDeep[q] = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            quadDeep <= '1;
            quadOn   <= '0;
        end else begin
            quadDeep <= next_quadDeep;
            quadOn   <= ~next_quadDeep;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            lanePower <= {NLANE{LP_DEEP}};
        end else begin
            for (int l = 0; l < NLANE; l++) begin
                if (next_quadDeep[l/4]) begin
                    lanePower[l] <= LP_DEEP;
                end else if (!portEnabled(portCtrl, l)) begin
                    lanePower[l] <= LP_DEEP;
                end else if (!laneUsed[l]) begin
                    lanePower[l] <= LP_P2;
                end else if (ltssmState[ownerOf(portCtrl, l)] == LT_L0 &&
                             !laneActive[l]) begin
                    lanePower[l] <= LP_P1;
                end else begin
                    lanePower[l] <= LP_P0;
                end
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    AST_LOWSWING_FOLLOWS: assert property (
        ##1 txCtrl[0].lowSwing == $past(swingCtrl[SW_LOWSW]))
        else $error("port0 swing mode does not follow enable");

    AST_NO_DEEMPH_LS: assert property (
        swingCtrl[SW_LOWSW+1] && $past(swingCtrl[SW_LOWSW+1])
        |-> !txCtrl[1].deemphOn)
        else $error("de-emphasis on during low swing");

    AST_STATUS_INVALID: assert property (
        $rose(swingCtrl[SW_LOWSW]) |=> !linkStatusTwo[0].valid)
        else $error("de-emphasis status still valid in low swing");

    AST_GEN1_LEVEL: assert property (
        swingCtrl[SW_LOWSW] && !gen2Rate[0] |=>
        txCtrl[0].level == $past(levelCtrl[3:0]))
        else $error("gen1 low swing level wrong");

    AST_GEN2_LEVEL: assert property (
        swingCtrl[SW_LOWSW] && gen2Rate[0] |=>
        txCtrl[0].level == $past(levelCtrl[7:4]))
        else $error("gen2 low swing level wrong");

    AST_MARGIN_HOLD: assert property (
        ltssmState[0] != LT_RLOCK && ltssmState[0] != LT_COMPL
        |=> marginApplied[0] == $past(marginApplied[0]))
        else $error("margin changed outside allowed state");

    AST_COMPL_MARGIN: assert property (
        ltssmState[0] == LT_COMPL ##1 ltssmState[0] == LT_COMPL
        |=> txCtrl[0].marginActive)
        else $error("compliance without margin drive");

    AST_QPD_DEEP: assert property (
        swingCtrl[SW_QPD] |=> !quadOn[0] && lanePower[0] == LP_DEEP
        && lanePower[3] == LP_DEEP)
        else $error("quad power-down not honoured");

    AST_USED_SAMPLE: assert property (
        ltssmState[ownerOf(portCtrl, 2)] == LT_DETECT
        |=> laneUsed[2] == $past(partnerDetect[2]))
        else $error("lane use not sampled in detect");

    AST_UNUSED_DOWN: assert property (
        !next_quadDeep[0] && portEnabled(portCtrl, 1) && !laneUsed[1]
        |=> lanePower[1] == LP_P2)
        else $error("unused lane not powered down");

    AST_EQ_ZERO_LANE: assert property (
        regWrEn && regAddr == ADDR_EQZ |=> rxEqZero == $past(regWrData))
        else $error("rx equalizer zero setting not taken");

    AST_X2_LANE_DEEP: assert property (
        !portEnabled(portCtrl, 2) |=> lanePower[2] == LP_DEEP)
        else $error("lane of disabled port not in deep power");

    AST_QUAD1_ALL_OFF: assert property (
        !portEnabled(portCtrl, 4) && !portEnabled(portCtrl, 5) &&
        !portEnabled(portCtrl, 6) && !portEnabled(portCtrl, 7)
        |=> !quadOn[1] && lanePower[7] == LP_DEEP)
        else $error("quad of disabled ports left on");

    AST_WIDTH_CUT_P1: assert property (
        !next_quadDeep[1] && portEnabled(portCtrl, 5) && laneUsed[5] &&
        ltssmState[ownerOf(portCtrl, 5)] == LT_L0 && !laneActive[5]
        |=> lanePower[5] == LP_P1)
        else $error("width-cut lane not held in P1");
endmodule

/* verification/sslp_link_partner.sv */
// Purpose: link partner stand-in on the lanes of the switch
// Assumes: presence and width are set by the bench
// Notes:   detect line carries noise outside Detect
module sslp_link_partner (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rstn,
    // bench controls
    input  wire logic       detectPhase,
    input  wire logic [7:0] lanesPresent,
    input  wire logic [7:0] lanesInWidth,
    // lane status
    output logic [7:0]      partnerDetect,
    output logic [7:0]      laneActive
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] noise;
    // receiver detect means nothing outside Detect, so it is never steady
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) noise <= 8'h5a;
        else noise <= {noise[6:0], noise[7] ^ noise[5]};
    end
    assign partnerDetect = detectPhase ? lanesPresent : noise;
    assign laneActive    = lanesPresent & lanesInWidth;
endmodule

/* verification/sslp_ctrl_tb.sv */
// Purpose: self-checking bench for swing and lane power control
// Assumes: all ports share one link state during a scenario
// Notes:   random fields from a fixed seed, corner codes mixed in
module sslp_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sslp_pkg::*;
    logic                      core_clk, rstn, regWrEn, regRdEn;
    logic [7:0]                regAddr, lanesPresent, lanesInWidth;
    logic [31:0]               regWrData, regRdData, rd, sw, lv, g2, mg;
    logic [NPORT-1:0][4:0]     ltssmState;
    logic [NPORT-1:0]          gen2Rate;
    logic [NLANE-1:0]          partnerDetect, laneActive;
    logic                      detectPhase;
    sslp_tx_s [NPORT-1:0]      txCtrl;
    sslp_lsts_s [NPORT-1:0]    linkStatusTwo;
    logic [NLANE-1:0][3:0]     rxEqZero, rxEqBoost;
    logic [NLANE-1:0][1:0]     lanePower;
    logic [NQUAD-1:0]          quadOn;
    int                        errors, tests_run;

    sslp_ctrl dut (.core_clk(core_clk), .rstn(rstn), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .ltssmState(ltssmState),
        .gen2Rate(gen2Rate), .partnerDetect(partnerDetect),
        .laneActive(laneActive), .txCtrl(txCtrl),
        .linkStatusTwo(linkStatusTwo), .rxEqZero(rxEqZero),
        .rxEqBoost(rxEqBoost), .lanePower(lanePower), .quadOn(quadOn));
    sslp_link_partner partner (.core_clk(core_clk), .rstn(rstn),
        .detectPhase(detectPhase), .lanesPresent(lanesPresent),
        .lanesInWidth(lanesInWidth), .partnerDetect(partnerDetect),
        .laneActive(laneActive));

    // ************************************************************
    // bus and check helpers
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regWrEn   <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge core_clk);
        regWrEn   <= 1'b0;
    endtask
    task automatic rdreg(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRdEn <= 1'b0;
        #1 d = regRdData;
    endtask
    // outputs are levels, so a few edges of slack only adds margin
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic setLt(input logic [4:0] s);
        @(posedge core_clk);
        ltssmState  <= {NPORT{s}};
        detectPhase <= (s == LT_DETECT);
    endtask
    function automatic logic [3:0] expLevel(input logic [31:0] l,
        input int p, input logic gen2, input logic low);
        logic [3:0] f;
        f = gen2 ? l[8*p+4 +: 4] : l[8*p +: 4];
        return low ? f : 4'h0;
    endfunction

    // ************************************************************
    // clock, watchdog, tests
    // ************************************************************
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        tally_and_finish();
    end
    initial begin
        rstn = 1'b0; regWrEn = 1'b0; regRdEn = 1'b0; regAddr = 8'h00;
        regWrData = 32'h0; ltssmState = {NPORT{LT_L0}}; gen2Rate = 4'h0;
        detectPhase = 1'b0; lanesPresent = 8'h00; lanesInWidth = 8'hff;
        errors = 0; tests_run = 0;
        void'($urandom(32'h19ef));
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        rdreg(ADDR_LEVEL, rd); check(rd, RST_LEVEL);
        rdreg(ADDR_PORT, rd); check(rd, RST_PORT);
        wr(ADDR_STATUS, 32'hffff_ffff);
        rdreg(ADDR_STATUS, rd); check(rd[7:0], 32'h0);
        // random swing setups, first pass pins codes 0x0 and 0xf
        for (int i = 0; i < 8; i++) begin
            sw = $urandom & 32'h0fff; lv = $urandom; g2 = $urandom;
            if (i == 0) lv = 32'hf00f_0ff0;
            wr(ADDR_LEVEL, lv);
            wr(ADDR_SWING, sw);
            @(posedge core_clk) gen2Rate <= g2[3:0];
            settle(3);
            for (int p = 0; p < NPORT; p++) begin
                check(txCtrl[p].lowSwing, sw[p]);
                check(txCtrl[p].deemphOn, !sw[p] && sw[4+p]);
                check(txCtrl[p].level, expLevel(lv, p, g2[p], sw[p]));
                check(linkStatusTwo[p].valid, !sw[p]);
                check(linkStatusTwo[p].deemph, !sw[p] && sw[4+p]);
            end
        end
        // margin held until a margin-changing state, compliance applies it
        wr(ADDR_SWING, 32'h0000_0f01);
        mg = ($urandom & 32'h0fff) | 32'h0249;
        wr(ADDR_MARGIN, mg); settle(4);
        for (int p = 0; p < NPORT; p++) begin
            check(txCtrl[p].marginSel, MARGIN_NORMAL);
        end
        setLt(LT_COMPL); settle(4);
        for (int p = 0; p < NPORT; p++) begin
            check(txCtrl[p].marginSel, mg[3*p +: 3]);
            check(txCtrl[p].marginActive, 1'b1);
            check(txCtrl[p].deemphOn, p != 0);
        end
        setLt(LT_L0);
        wr(ADDR_MARGIN, ~mg & 32'h0fff); settle(4);
        check(txCtrl[1].marginSel, mg[5:3]);
        setLt(LT_RLOCK); settle(3); setLt(LT_L0); settle(3);
        check(txCtrl[1].marginSel, {29'h0, ~mg[5:3]});
        // equalizer controls, unmapped write must not alias
        sw = $urandom; lv = $urandom;
        wr(ADDR_EQZ, sw); wr(ADDR_EQB, lv); wr(8'h20, ~sw); settle(3);
        check(rxEqZero, sw);
        check(rxEqBoost, lv);
        rdreg(ADDR_EQZ, rd); check(rd, sw);
        rdreg(8'h20, rd); check(rd, 32'h0);
        // lane use from detection, then width cut and retrain
        wr(ADDR_SWING, 32'h0);
        @(posedge core_clk) lanesPresent <= 8'h31;
        setLt(LT_DETECT); settle(3); setLt(LT_L0); settle(3);
        check(lanePower, 16'ha0a8);
        check(quadOn, 2'h3);
        @(posedge core_clk) lanesInWidth <= 8'hdf;
        settle(3);
        check(lanePower[5], LP_P1);
        @(posedge core_clk) lanesInWidth <= 8'hff;
        @(posedge core_clk) lanesPresent <= 8'h33;
        setLt(LT_DETECT); settle(3); setLt(LT_L0); settle(3);
        check(lanePower[1], LP_P0);
        // port disables: x2 lanes only, x4 quad, then whole quad
        wr(ADDR_PORT, RST_PORT & ~32'h2); settle(3);
        check(lanePower[3:2], {2{LP_DEEP}});
        check(quadOn, 2'h3);
        wr(ADDR_PORT, RST_PORT & ~32'h6); settle(3);
        check(quadOn, 2'h1);
        wr(ADDR_PORT, RST_PORT & ~32'h7); settle(3);
        check(quadOn, 2'h0);
        wr(ADDR_PORT, RST_PORT); wr(ADDR_SWING, 32'h1000); settle(3);
        check(quadOn, 2'h2);
        tally_and_finish();
    end
endmodule
